//--- core/abu_pkg.sv
// Package for the address breakpoint unit: register map, field positions and constants.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit CPU address bus.
`default_nettype none

package abu_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ABU_OFS_CTRL = 8'h00;
	localparam logic [7:0] ABU_OFS_ADDR_HI = 8'h04;
	localparam logic [7:0] ABU_OFS_ADDR_LO = 8'h08;
	localparam logic [7:0] ABU_OFS_FLAG_CLR = 8'h0c;
	localparam int ABU_ENABLE_BIT = 7;
	localparam int ABU_ACTIVE_BIT = 6;
	localparam int ABU_FLAG_CLR_BIT = 0;
	localparam logic [7:0] ABU_BYTE_RESET = 8'h00;
	localparam logic [31:0] ABU_RDATA_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Vectors and opcodes
	// ----------------------------------------------------------------
	localparam logic [15:0] ABU_VEC_USER = 16'hfffc;
	localparam logic [15:0] ABU_VEC_MON = 16'hfefc;
	localparam logic [7:0] ABU_SWI_OPCODE = 8'h83;

	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] ABU_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ABU_HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0] {
		ABU_ST_IDLE,
		ABU_ST_BREAK,
		ABU_ST_DONE
	} abu_state_t;
endpackage : abu_pkg

`default_nettype wire

//--- core/abu_ahb_slave.sv
// AHB-Lite slave front end: captures the address phase and returns write strobes.
// Assumes a single master, word transfers only, and hready tied to this hreadyout.
`default_nettype none

module abu_ahb_slave
	import abu_pkg::*;
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	output logic wr_en_out,
	output logic rd_en_out,
	output logic [7:0] wr_addr_out,
	output logic [7:0] rd_addr_out
);
	logic wr_pend_ff;
	logic [7:0] addr_ff;
	logic req;

	// ----------------------------------------------------------------
	// Address phase capture
	// ----------------------------------------------------------------
	// Reads decode in the address phase so the slave never stalls.
	assign req = hsel_in && hready_in &&
		(htrans_in == ABU_HTRANS_NONSEQ || htrans_in == ABU_HTRANS_SEQ);
	assign rd_en_out = req && !hwrite_in;
	assign rd_addr_out = haddr_in[7:0];
	assign wr_en_out = wr_pend_ff;
	assign wr_addr_out = addr_ff;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= req && hwrite_in;
			if (req) begin
				addr_ff <= haddr_in[7:0];
			end
		end
	end
endmodule // abu_ahb_slave

`default_nettype wire

//--- core/abu_matcher.sv
// Address comparator for CPU instruction-fetch cycles.
// Assumes fetch_in qualifies an opcode or operand fetch on addr_in; cpu_master_in marks CPU ownership.
`default_nettype none

module abu_matcher
	import abu_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [ADDR_W-1:0] brk_addr_in,
	input wire logic fetch_in,
	input wire logic cpu_master_in,
	input wire logic enable_in,
	output logic hit_out
);
	initial begin
		if (ADDR_W != 16) begin
			$error("abu_matcher supports only a 16-bit address");
		end
	end

	// Data cycles and other masters never match.
	assign hit_out = enable_in && fetch_in && cpu_master_in && (addr_in == brk_addr_in);
endmodule // abu_matcher

`default_nettype wire

//--- core/abu_core.sv
// Address breakpoint unit top: registers, break state and system control outputs.
// Assumes a CPU that reports opcode starts, fetches, returns and low-power state.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none

module abu_core
	import abu_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic [2:0] hsize_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic [ADDR_W-1:0] cpu_addr_in,
	input wire logic cpu_fetch_in,
	input wire logic cpu_master_in,
	input wire logic opcode_start_in,
	input wire logic rti_done_in,
	input wire logic low_power_in,
	input wire logic monitor_mode_in,
	input wire logic test_high_voltage_in,
	output logic break_req_out,
	output logic force_swi_out,
	output logic [7:0] swi_opcode_out,
	output logic [ADDR_W-1:0] break_vector_out,
	output logic break_state_out,
	output logic timer_freeze_out,
	output logic watchdog_disable_out,
	output logic status_clear_allow_out
);
	logic enable_ff;
	logic active_ff;
	logic [7:0] addr_hi_ff;
	logic [7:0] addr_lo_ff;
	logic flag_clear_enable_ff;
	logic armed_ff;
	logic pend_ff;
	logic [31:0] rdata_ff;
	abu_state_t state_ff;
	abu_state_t nxt_state;
	logic wr_en;
	logic rd_en;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic hit;
	logic sw_force;
	logic flag_wr;
	logic in_break;
	logic addr_new_ff;

	initial begin
		if (ADDR_W != 16) begin
			$error("abu_core supports only a 16-bit address");
		end
	end

	function automatic logic [7:0] ctrl_byte(input logic en, input logic act);
		logic [7:0] b;
		b = 8'h00;
		b[ABU_ENABLE_BIT] = en;
		b[ABU_ACTIVE_BIT] = act;
		return b;
	endfunction

	function automatic logic addr_byte_wr(input logic en, input logic [7:0] a);
		return en && (a == ABU_OFS_ADDR_HI || a == ABU_OFS_ADDR_LO);
	endfunction

	// ----------------------------------------------------------------
	// Bus front end and comparator
	// ----------------------------------------------------------------
	abu_ahb_slave u_bus (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hready_in(hready_in),
		.wr_en_out(wr_en),
		.rd_en_out(rd_en),
		.wr_addr_out(wr_addr),
		.rd_addr_out(rd_addr)
	);

	// A sleeping CPU keeps its fetch on the bus, so this gate is what stops a hit in low power.
	abu_matcher #(.ADDR_W(ADDR_W)) u_match (
		.addr_in(cpu_addr_in),
		.brk_addr_in({addr_hi_ff, addr_lo_ff}),
		.fetch_in(cpu_fetch_in && !low_power_in),
		.cpu_master_in(cpu_master_in),
		.enable_in(enable_ff && armed_ff),
		.hit_out(hit)
	);

	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign hrdata_out = rdata_ff;
	assign flag_wr = wr_en && wr_addr == ABU_OFS_CTRL;
	assign sw_force = flag_wr && hwdata_in[ABU_ACTIVE_BIT];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			enable_ff <= 1'b0;
			addr_hi_ff <= ABU_BYTE_RESET;
			addr_lo_ff <= ABU_BYTE_RESET;
			flag_clear_enable_ff <= 1'b0;
		end else if (wr_en) begin
			if (wr_addr == ABU_OFS_CTRL) begin
				enable_ff <= hwdata_in[ABU_ENABLE_BIT];
			end else if (wr_addr == ABU_OFS_ADDR_HI) begin
				addr_hi_ff <= hwdata_in[7:0];
			end else if (wr_addr == ABU_OFS_ADDR_LO) begin
				addr_lo_ff <= hwdata_in[7:0];
			end else if (wr_addr == ABU_OFS_FLAG_CLR) begin
				flag_clear_enable_ff <= hwdata_in[ABU_FLAG_CLR_BIT];
			end
		end
	end

	// A match sets the flag and wins over a clear in the same cycle.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			active_ff <= 1'b0;
		end else if (hit || sw_force) begin
			active_ff <= 1'b1;
		end else if (flag_wr) begin
			active_ff <= 1'b0;
		end
	end

	// Clearing the flag in the handler with no address rewrite since break entry disarms the comparator until the address is rewritten.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			armed_ff <= 1'b1;
		end else if (addr_byte_wr(wr_en, wr_addr)) begin
			armed_ff <= 1'b1;
		end else if (flag_wr && !hwdata_in[ABU_ACTIVE_BIT] && in_break && !addr_new_ff) begin
			armed_ff <= 1'b0;
		end
	end

	// Remembers an address rewrite since the last break entry. Handlers load the new
	// address before clearing the flag, so that order must leave the comparator armed.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			addr_new_ff <= 1'b0;
		end else if (addr_byte_wr(wr_en, wr_addr)) begin
			addr_new_ff <= 1'b1;
		end else if (break_req_out) begin
			addr_new_ff <= 1'b0;
		end
	end

	// Read data; unmapped words read zero, as do the unused control bits.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_ff <= ABU_RDATA_RESET;
		end else if (rd_en) begin
			if (rd_addr == ABU_OFS_CTRL) begin
				rdata_ff <= {24'h000000, ctrl_byte(enable_ff, active_ff)};
			end else if (rd_addr == ABU_OFS_ADDR_HI) begin
				rdata_ff <= {24'h000000, addr_hi_ff};
			end else if (rd_addr == ABU_OFS_ADDR_LO) begin
				rdata_ff <= {24'h000000, addr_lo_ff};
			end else if (rd_addr == ABU_OFS_FLAG_CLR) begin
				rdata_ff <= {31'h00000000, flag_clear_enable_ff};
			end else begin
				rdata_ff <= ABU_RDATA_RESET;
			end
		end
	end

	// ----------------------------------------------------------------
	// Break request and state
	// ----------------------------------------------------------------
	// A pending request waits for the next opcode boundary, so an operand
	// match lets the current instruction finish.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pend_ff <= 1'b0;
		end else if (state_ff == ABU_ST_IDLE && (hit || sw_force)) begin
			pend_ff <= 1'b1;
		end else if (state_ff != ABU_ST_IDLE) begin
			pend_ff <= 1'b0;
		end
	end

	// An opcode fetch match breaks at once, before that opcode runs.
	assign break_req_out = (state_ff == ABU_ST_IDLE) &&
		((hit && opcode_start_in) || (pend_ff && opcode_start_in));
	assign force_swi_out = break_req_out;
	assign swi_opcode_out = ABU_SWI_OPCODE;
	assign break_vector_out = monitor_mode_in ? ABU_VEC_MON : ABU_VEC_USER;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ABU_ST_IDLE: begin
				if (break_req_out) begin
					nxt_state = ABU_ST_BREAK;
				end
			end
			ABU_ST_BREAK: begin
				if (rti_done_in) begin
					nxt_state = ABU_ST_DONE;
				end
			end
			default: begin
				nxt_state = ABU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_ff <= ABU_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// System control outputs
	// ----------------------------------------------------------------
	assign in_break = state_ff == ABU_ST_BREAK;
	assign break_state_out = in_break;
	assign timer_freeze_out = in_break;
	assign watchdog_disable_out = in_break && test_high_voltage_in;
	assign status_clear_allow_out = !in_break || flag_clear_enable_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	opcode_match_a: assert property (hit && opcode_start_in && state_ff == ABU_ST_IDLE
		|-> break_req_out ##1 in_break) else $error("opcode match not taken");
	operand_match_a: assert property (hit && !opcode_start_in && state_ff == ABU_ST_IDLE
		|-> !break_req_out ##1 pend_ff) else $error("operand match not deferred");
	sw_force_a: assert property (sw_force && state_ff == ABU_ST_IDLE && !break_req_out
		|=> active_ff && pend_ff) else $error("software break lost");
	pend_hold_a: assert property (pend_ff && !opcode_start_in |-> !break_req_out)
		else $error("pending break taken inside an instruction");
	rti_exit_a: assert property (in_break && rti_done_in |=> !in_break ##1
		state_ff == ABU_ST_IDLE) else $error("return did not end break");
	break_hold_a: assert property (in_break && !rti_done_in |=> in_break)
		else $error("break ended without return");
	busy_refuse_a: assert property (state_ff != ABU_ST_IDLE |-> !break_req_out)
		else $error("break requested while busy");
	swi_sub_a: assert property (force_swi_out |-> swi_opcode_out == ABU_SWI_OPCODE)
		else $error("wrong substituted opcode");
	vector_sel_a: assert property (break_req_out |-> break_vector_out ==
		(monitor_mode_in ? ABU_VEC_MON : ABU_VEC_USER)) else $error("wrong break vector");
	timer_stop_a: assert property (in_break |-> timer_freeze_out
		&& force_swi_out == 1'b0) else $error("timer not frozen in break");
	timer_run_a: assert property (!in_break |-> !timer_freeze_out)
		else $error("timer frozen outside break");
	wdog_gate_a: assert property (watchdog_disable_out |-> in_break
		&& test_high_voltage_in) else $error("watchdog gated outside break");
	wdog_test_a: assert property (in_break && test_high_voltage_in
		|-> watchdog_disable_out) else $error("watchdog not gated in break");
	clear_gate_a: assert property (in_break && !flag_clear_enable_ff
		|-> !status_clear_allow_out) else $error("status clear allowed in break");
	status_free_a: assert property (!in_break |-> status_clear_allow_out)
		else $error("status clear blocked outside break");
	low_power_a: assert property (low_power_in |-> !hit)
		else $error("match in low power mode");

	// ----------------------------------------------------------------
	// Checks: registers and gating
	// ----------------------------------------------------------------
	flag_set_a: assert property (hit |=> active_ff)
		else $error("active flag not set on match");
	sw_set_a: assert property (sw_force |=> active_ff)
		else $error("active flag not set by software");
	flag_clear_a: assert property (flag_wr && !hwdata_in[ABU_ACTIVE_BIT] && !hit
		|=> !active_ff) else $error("active flag not cleared");
	disarm_a: assert property (!armed_ff && !wr_en |=> !hit)
		else $error("break after clear without new address");
	rearm_a: assert property (flag_wr && in_break && addr_new_ff |=> armed_ff)
		else $error("new address lost on flag clear");
	enable_off_a: assert property (!enable_ff |-> !hit)
		else $error("match while breaks disabled");
	enable_set_a: assert property (flag_wr && hwdata_in[ABU_ENABLE_BIT] |=> enable_ff)
		else $error("enable bit not set");
	enable_clr_a: assert property (flag_wr && !hwdata_in[ABU_ENABLE_BIT] |=> !enable_ff)
		else $error("enable bit not cleared");
	addr_match_a: assert property (hit |-> cpu_addr_in == {addr_hi_ff, addr_lo_ff})
		else $error("match on a different address");
	fetch_only_a: assert property (!cpu_fetch_in || !cpu_master_in |-> !hit)
		else $error("match outside a processor fetch");
	ctrl_read_a: assert property (rd_en && rd_addr == ABU_OFS_CTRL
		|=> hrdata_out[5:0] == 6'h00 && hrdata_out[31:8] == 24'h000000)
		else $error("unused control bits set");
	hi_write_a: assert property (wr_en && wr_addr == ABU_OFS_ADDR_HI
		|=> addr_hi_ff == $past(hwdata_in[7:0])) else $error("high address byte not written");
	lo_write_a: assert property (wr_en && wr_addr == ABU_OFS_ADDR_LO
		|=> addr_lo_ff == $past(hwdata_in[7:0])) else $error("low address byte not written");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	enter_c: cover property (break_req_out ##1 in_break);
	sw_c: cover property (sw_force ##[1:20] break_req_out);
	exit_c: cover property (in_break ##[1:50] !in_break);
	mon_c: cover property (break_req_out && monitor_mode_in);
	rearm_c: cover property (in_break && flag_wr && addr_new_ff);
endmodule // abu_core

`default_nettype wire

//--- dv/abu_cpu_model.sv
// CPU-side partner: a fetch sequencer of two-byte instructions that stops on a break.
// Assumes the bench steers mode, start address and the return strobe on the bus clock.
`default_nettype none

module abu_cpu_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_in,
	input wire logic load_in,
	input wire logic [15:0] start_in,
	input wire logic rti_cmd_in,
	input wire logic break_req_in,
	input wire logic force_swi_in,
	input wire logic [7:0] swi_opcode_in,
	output logic [15:0] addr_out,
	output logic fetch_out,
	output logic master_out,
	output logic opcode_start_out,
	output logic low_power_out,
	output var logic rti_done_out,
	output var logic [15:0] brk_at_out,
	output var logic [7:0] swi_seen_out,
	output var logic [7:0] brk_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Fetch sequencer
	// ----------------------------------------------------------------
	logic [15:0] pc_ff;
	logic halt_ff;
	logic run;
	// Mode 1 runs, 2 sleeps on one fetch, 3 lends the bus to another master.
	// A sleeping CPU keeps its fetch on the bus, so only the low-power gate can stop a hit.
	assign run = (mode_in == 2'h1) && !halt_ff && !rti_done_out;
	assign fetch_out = run || (mode_in[1] && !halt_ff);
	assign addr_out = fetch_out ? pc_ff : ~pc_ff;
	assign master_out = (mode_in != 2'h3);
	assign opcode_start_out = fetch_out && !pc_ff[0];
	assign low_power_out = (mode_in == 2'h2);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_ff <= 16'h0000;
			halt_ff <= 1'b0;
			rti_done_out <= 1'b0;
			brk_at_out <= 16'h0000;
			swi_seen_out <= 8'h00;
			brk_count_out <= 8'h00;
		end else begin
			rti_done_out <= halt_ff && rti_cmd_in;
			if (load_in) begin
				pc_ff <= start_in;
			end else if (run && !break_req_in) begin
				pc_ff <= pc_ff + 16'h0001;
			end
			if (break_req_in) begin
				halt_ff <= 1'b1;
				brk_at_out <= pc_ff;
				swi_seen_out <= force_swi_in ? swi_opcode_in : 8'h00;
				brk_count_out <= brk_count_out + 8'h01;
			end else if (rti_cmd_in) begin
				halt_ff <= 1'b0;
			end
		end
	end
endmodule // abu_cpu_model

`default_nettype wire

//--- dv/address_breakpoint_unit_test.sv
// Self-checking bench for the breakpoint unit: registers, fetch matching and break state.
// Assumes a bus slave with no wait states and the CPU model on the fetch side.
`default_nettype none

module address_breakpoint_unit_test
	import abu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, mon = 1'b0, thv = 1'b0, load = 1'b0, return_from_interrupt = 1'b0;
	logic [1:0] htrans = 2'h0, mode = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [15:0] start = 16'h0, caddr, brk_at, bvec, s, t;
	logic [7:0] software_interrupt_opcode, cnt, swop;
	logic hready, hresp, breq, fswi, bst, frz, wdd, sca, fe, ms, os, lp, rd;
	int failures = 0, n_checks = 0, seed, i;
	always #20 mclk_in = ~mclk_in;
	abu_core dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hsize_in(3'h2), .hwrite_in(hwrite),
		.hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .cpu_addr_in(caddr), .cpu_fetch_in(fe), .cpu_master_in(ms),
		.opcode_start_in(os), .rti_done_in(rd), .low_power_in(lp), .monitor_mode_in(mon),
		.test_high_voltage_in(thv), .break_req_out(breq), .force_swi_out(fswi),
		.swi_opcode_out(swop), .break_vector_out(bvec), .break_state_out(bst),
		.timer_freeze_out(frz), .watchdog_disable_out(wdd), .status_clear_allow_out(sca));
	abu_cpu_model cpu_u (.clk_in(mclk_in), .rst_in(sys_rst_in), .mode_in(mode), .load_in(load),
		.start_in(start), .rti_cmd_in(return_from_interrupt), .break_req_in(breq), .force_swi_in(fswi),
		.swi_opcode_in(swop), .addr_out(caddr), .fetch_out(fe), .master_out(ms),
		.opcode_start_out(os), .low_power_out(lp), .rti_done_out(rd), .brk_at_out(brk_at),
		.swi_seen_out(software_interrupt_opcode), .brk_count_out(cnt));
	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge mclk_in);
		hsel <= 1'b1;
		htrans <= ABU_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge mclk_in); while (hready !== 1'b1);
		q = hrdata;
		chk("hresp", 0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(what, {24'h0, e}, q);
	endtask
	task automatic seta(input logic [15:0] a);
		wr(ABU_OFS_ADDR_HI, a[15:8]);
		wr(ABU_OFS_ADDR_LO, a[7:0]);
	endtask
	// Load first, then start, so no fetch is made from a stale count.
	task automatic go(input logic [15:0] a, input logic [1:0] m);
		@(posedge mclk_in);
		start <= a;
		load <= 1'b1;
		@(posedge mclk_in);
		load <= 1'b0;
		mode <= m;
	endtask
	// Opcodes sit on even addresses, so an operand hit stops on the next one.
	function automatic logic [15:0] stop_at(input logic [15:0] a);
		return a + {15'h0, a[0]};
	endfunction
	task automatic expect_brk(input logic [15:0] a);
		logic [7:0] n0;
		n0 = cnt;
		for (int k = 0; k < 200 && cnt === n0; k++) @(posedge mclk_in);
		@(posedge mclk_in);
		chk("count", {24'h0, n0 + 8'h01}, {24'h0, cnt});
		chk("at", {16'h0, stop_at(a)}, {16'h0, brk_at});
		chk("swi", {24'h0, ABU_SWI_OPCODE}, {24'h0, software_interrupt_opcode});
		chk("state", 1, {31'h0, bst});
		chk("freeze", 1, {31'h0, frz});
	endtask
	task automatic leave(input logic [7:0] c);
		wr(ABU_OFS_CTRL, c);
		@(posedge mclk_in);
		return_from_interrupt <= 1'b1;
		@(posedge mclk_in);
		return_from_interrupt <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk("end", 0, {31'h0, bst});
	endtask
	task automatic none(input logic [7:0] n0);
		repeat (80) @(posedge mclk_in);
		chk("quiet", {24'h0, n0}, {24'h0, cnt});
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge mclk_in);
		failures++;
		stop_test();
	end
	initial begin
		seed = 54;
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rdc("ctrl", ABU_OFS_CTRL, 8'h00);
		rdc("hi", ABU_OFS_ADDR_HI, 8'h00);
		rdc("lo", ABU_OFS_ADDR_LO, 8'h00);
		rdc("fce", ABU_OFS_FLAG_CLR, 8'h00);
		rdc("unmapped", 8'h10, 8'h00);
		wr(ABU_OFS_CTRL, 8'hbf);
		rdc("ctrl", ABU_OFS_CTRL, 8'h80);
		for (i = 0; i < 6; i++) begin
			r = $random(seed);
			seta(r[15:0]);
			rdc("hi", ABU_OFS_ADDR_HI, r[15:8]);
			rdc("lo", ABU_OFS_ADDR_LO, r[7:0]);
		end
		$display("test registers done");
		r = $random(seed);
		s = {r[15:1], 1'b0} & 16'hff00;
		t = s + {10'h0, r[20:16], 1'b0} + 16'h0004;
		wr(ABU_OFS_CTRL, 8'h00);
		seta(t);
		go(s, 2'h1);
		none(cnt);
		mode <= 2'h0;
		wr(ABU_OFS_CTRL, 8'h80);
		go(s, 2'h1);
		expect_brk(t);
		chk("vector", {16'h0, ABU_VEC_USER}, {16'h0, bvec});
		rdc("ctrl", ABU_OFS_CTRL, 8'hc0);
		leave(8'h80);
		none(cnt);
		mode <= 2'h0;
		seta(t + 16'h0001);
		go(s, 2'h1);
		expect_brk(t + 16'h0001);
		seta(t + 16'h0010);
		leave(8'h80);
		expect_brk(t + 16'h0010);
		leave(8'h00);
		mode <= 2'h0;
		$display("test address break done");
		mon <= 1'b1;
		thv <= 1'b1;
		wr(ABU_OFS_CTRL, 8'h40);
		go(t, 2'h1);
		expect_brk(t);
		chk("vector", {16'h0, ABU_VEC_MON}, {16'h0, bvec});
		chk("wdog", 1, {31'h0, wdd});
		chk("clear", 0, {31'h0, sca});
		wr(ABU_OFS_FLAG_CLR, 8'h01);
		@(posedge mclk_in);
		chk("clear", 1, {31'h0, sca});
		wr(ABU_OFS_FLAG_CLR, 8'h00);
		leave(8'h00);
		chk("wdog", 0, {31'h0, wdd});
		mode <= 2'h0;
		mon <= 1'b0;
		thv <= 1'b0;
		$display("test software break done");
		seta(s);
		wr(ABU_OFS_CTRL, 8'h80);
		go(s, 2'h2);
		none(cnt);
		mode <= 2'h3;
		none(cnt);
		mode <= 2'h1;
		expect_brk(s);
		leave(8'h00);
		mode <= 2'h0;
		$display("test gated fetch done");
		stop_test();
	end
endmodule // address_breakpoint_unit_test

`default_nettype wire
